/* design/rrs_run_ctrl.sv */
// What this block does
// [R1] remote stop waits for scan end
// [R2] run after remote stop restarts step 0
// [R3] run contact selectable among X0 to 1FFF
// [R4] run contact off runs, on stops
// [R5] any source stops; all must release
// [R6] remote requests only act with key RUN; reset and latch clear are also taken with the key at STOP
// [R7] end of scan sets pause status flag
// [R8] one more scan, then pause
// [R9] pause holds outputs as they were
// [R10] dropping contact or enable releases pause
// [R11] pause contact ignored if equals run contact
// [R12] pause command: flag at next end, pause at the end after
// [R13] run command resumes from step 0
// [R14] reset refused while running
// [R15] reset allowed after error or remote stop
// [R16] reset needs enable parameter set beforehand
// [R17] reset only by command, never contact
// [R18] latch clear refused while running
// [R19] latch clear spares non-clearable retained range
// [R20] priority stop, pause, step-run, run
// [R21] step-run executes single steps from address
// [R22] stop halts program, all outputs off
// [R23] requests latched, evaluated at scan end
`timescale 1ns/10ps
`include "rrs_consts.svh"

module rrs_run_ctrl #(
    parameter int NUM_X  = `RRS_NUM_X,
    parameter int SEL_W  = `RRS_SEL_W,
    parameter int STEP_W = `RRS_STEP_W
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   key_run,
    input  wire logic [NUM_X-1:0]       x_in,
    input  wire logic                   run_contact_en,
    input  wire logic [SEL_W-1:0]       run_contact_sel,
    input  wire logic                   pause_contact_en,
    input  wire logic [SEL_W-1:0]       pause_contact_sel,
    input  wire logic                   pause_enable_flag,
    input  wire logic                   reset_enable,
    input  wire logic                   diag_error,
    input  wire logic                   scan_end,
    input  wire logic                   cmd_valid,
    input  wire logic [`RRS_CMD_W-1:0]  cmd_code,
    input  wire logic                   cmd_src,
    input  wire logic [STEP_W-1:0]      cmd_step_addr,
    output rrs_pkg::rrs_state_t         run_state,
    output logic                        exec_enable,
    output logic                        restart_step0,
    output logic                        outputs_off,
    output logic                        outputs_hold,
    output logic                        pause_status_flag,
    output logic                        step_exec,
    output logic [STEP_W-1:0]           step_addr,
    output logic                        cpu_reset,
    output logic                        clear_unlatched,
    output logic                        clear_latch_clearable,
    output logic                        cmd_ack,
    output logic                        cmd_nak
);
    import rrs_pkg::*;

    // two-stage synchronisers on key and input image
    logic             key_m_q;
    logic             key_s_q;
    logic [NUM_X-1:0] x_m_q;
    logic [NUM_X-1:0] x_s_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            key_m_q <= 1'h0;
            key_s_q <= 1'h0;
            x_m_q   <= '0;
            x_s_q   <= '0;
        end else begin
            key_m_q <= key_run;
            key_s_q <= key_m_q;
            x_m_q   <= x_in;
            x_s_q   <= x_m_q;
        end
    end

    // contact decode
    logic run_contact_on;
    logic pause_contact_on;
    logic pause_contact_live;

    always_comb begin
        run_contact_on     = run_contact_en && x_s_q[run_contact_sel]; // R3
        // a shared contact would make run and pause fight
        pause_contact_live = pause_contact_en &&
                             !(run_contact_en && (pause_contact_sel == run_contact_sel)); // R11
        pause_contact_on   = pause_contact_live && x_s_q[pause_contact_sel] &&
                             pause_enable_flag; // R7
    end

    // state and request latches
    rrs_state_t                   state_q, state_d;
    logic [`RRS_NUM_SRC-1:0]      stop_src_q, stop_src_d;
    logic [`RRS_NUM_SRC-1:0]      run_pend_q, run_pend_d;
    logic                         pause_cmd_q, pause_cmd_d;
    logic                         step_req_q, step_req_d;
    logic                         pstat_q, pstat_d;
    logic                         restart_q, restart_d;
    logic                         step_exec_q, step_exec_d;
    logic [STEP_W-1:0]            step_addr_q, step_addr_d;
    logic                         reset_q, reset_d;
    logic                         clr_q, clr_d;
    logic                         ack_q, ack_d;
    logic                         nak_q, nak_d;
    logic                         eval;
    logic                         stop_any;
    logic                         pause_req;
    logic                         is_stopped;

    always_comb begin
        state_d     = state_q;
        stop_src_d  = stop_src_q;
        run_pend_d  = run_pend_q;
        pause_cmd_d = pause_cmd_q;
        step_req_d  = step_req_q;
        pstat_d     = pstat_q;
        restart_d   = 1'h0;
        step_exec_d = 1'h0;
        step_addr_d = step_addr_q;
        reset_d     = 1'h0;
        clr_d       = 1'h0;
        ack_d       = 1'h0;
        nak_d       = 1'h0;
        is_stopped  = (state_q == RRS_ST_STOP) || diag_error;

        // running scans evaluate only at END; idle states every cycle
        eval = (state_q == RRS_ST_RUN) ? scan_end : 1'h1; // R1 R23
        // consume pending RUN first so a STOP taken now still latches
        if (eval) begin
            stop_src_d = stop_src_d & ~run_pend_q; // R5
            if (|run_pend_q) begin
                pause_cmd_d = 1'h0; // R13
                step_req_d  = 1'h0;
            end
            run_pend_d = run_pend_d & ~run_pend_q;
        end

        // latch mid-scan requests; they act at the next evaluation
        if (cmd_valid) begin // R23
            unique case (cmd_code)
                `RRS_CMD_RUN: begin
                    run_pend_d[cmd_src] = 1'h1;
                    ack_d               = 1'h1;
                end
                `RRS_CMD_STOP: begin
                    stop_src_d[cmd_src] = 1'h1; // R5
                    run_pend_d[cmd_src] = 1'h0;
                    ack_d               = 1'h1;
                end
                `RRS_CMD_PAUSE: begin
                    pause_cmd_d = 1'h1; // R12
                    ack_d       = 1'h1;
                end
                `RRS_CMD_STEP: begin
                    // step-run belongs to the programming tool only
                    if (cmd_src == `RRS_SRC_TOOL) begin // R21
                        ack_d = 1'h1;
                        if (state_q == RRS_ST_STEP) begin
                            step_exec_d = 1'h1;
                        end else begin
                            step_req_d  = 1'h1;
                            step_addr_d = cmd_step_addr;
                        end
                    end else begin
                        nak_d = 1'h1;
                    end
                end
                `RRS_CMD_RESET: begin
                    // contacts have no path here, only commands
                    if (reset_enable && is_stopped) begin // R14 R15 R16 R17
                        reset_d = 1'h1;
                        ack_d   = 1'h1;
                    end else begin
                        nak_d = 1'h1;
                    end
                end
                `RRS_CMD_LCLR: begin
                    if (state_q == RRS_ST_STOP) begin // R18
                        clr_d = 1'h1; // R19
                        ack_d = 1'h1;
                    end else begin
                        nak_d = 1'h1;
                    end
                end
                default: begin
                    nak_d = 1'h1;
                end
            endcase
        end

        stop_any  = run_contact_on || (|stop_src_q); // R4 R5
        pause_req = pause_contact_on || pause_cmd_q;

        if (!key_s_q) begin
            state_d = RRS_ST_STOP; // R6
            pstat_d = 1'h0;
        end else if (eval) begin
            if (stop_any) begin // R20
                state_d = RRS_ST_STOP;
                pstat_d = 1'h0;
            end else if (pause_req) begin // R20
                if (state_q == RRS_ST_RUN) begin
                    if (pstat_q) begin
                        state_d = RRS_ST_PAUSE; // R8
                    end else begin
                        pstat_d = 1'h1; // R7 R12
                    end
                end else if (state_q != RRS_ST_PAUSE) begin
                    state_d   = RRS_ST_RUN;
                    restart_d = 1'h1;
                end
            end else if (step_req_q) begin // R20
                state_d = RRS_ST_STEP; // R21
                pstat_d = 1'h0;
            end else begin
                pstat_d = 1'h0; // R10
                if (state_q != RRS_ST_RUN) begin
                    state_d   = RRS_ST_RUN;
                    restart_d = 1'h1; // R2 R10 R13
                end
            end
        end

        // a reset clears every remote request
        if (reset_d) begin
            stop_src_d  = '0;
            run_pend_d  = '0;
            pause_cmd_d = 1'h0;
            step_req_d  = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q     <= RRS_ST_STOP;
            stop_src_q  <= '0;
            run_pend_q  <= '0;
            pause_cmd_q <= 1'h0;
            step_req_q  <= 1'h0;
            pstat_q     <= 1'h0;
            restart_q   <= 1'h0;
            step_exec_q <= 1'h0;
            step_addr_q <= '0;
            reset_q     <= 1'h0;
            clr_q       <= 1'h0;
            ack_q       <= 1'h0;
            nak_q       <= 1'h0;
        end else begin
            state_q     <= state_d;
            stop_src_q  <= stop_src_d;
            run_pend_q  <= run_pend_d;
            pause_cmd_q <= pause_cmd_d;
            step_req_q  <= step_req_d;
            pstat_q     <= pstat_d;
            restart_q   <= restart_d;
            step_exec_q <= step_exec_d;
            step_addr_q <= step_addr_d;
            reset_q     <= reset_d;
            clr_q       <= clr_d;
            ack_q       <= ack_d;
            nak_q       <= nak_d;
        end
    end

    // output flags derived from next state so they leave a flop
    logic exec_q, exec_d;
    logic off_q, off_d;
    logic hold_q, hold_d;

    always_comb begin
        exec_d = (state_d == RRS_ST_RUN);
        off_d  = (state_d == RRS_ST_STOP); // R22
        hold_d = (state_d == RRS_ST_PAUSE); // R9
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            exec_q <= 1'h0;
            off_q  <= 1'h1;
            hold_q <= 1'h0;
        end else begin
            exec_q <= exec_d;
            off_q  <= off_d;
            hold_q <= hold_d;
        end
    end

    assign run_state             = state_q;
    assign exec_enable           = exec_q;
    assign restart_step0         = restart_q;
    assign outputs_off           = off_q;
    assign outputs_hold          = hold_q;
    assign pause_status_flag     = pstat_q;
    assign step_exec             = step_exec_q;
    assign step_addr             = step_addr_q;
    assign cpu_reset             = reset_q;
    // retained ranges marked not clearable have no strobe at all
    assign clear_unlatched       = clr_q;
    assign clear_latch_clearable = clr_q;
    assign cmd_ack               = ack_q;
    assign cmd_nak               = nak_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_stop_waits_end: assert property ( // R1
        (state_q == RRS_ST_RUN) && !scan_end && key_s_q |=> state_q != RRS_ST_STOP)
        else $error("left run without scan end");

    a_run_restart: assert property ( // R2
        (state_q == RRS_ST_STOP) && (state_d == RRS_ST_RUN) |=> restart_q && exec_q)
        else $error("restart missing on return to run");

    a_key_stop_forces: assert property ( // R6
        !key_s_q |=> state_q == RRS_ST_STOP && off_q)
        else $error("key stop did not stop");

    a_contact_stops: assert property ( // R4
        key_s_q && run_contact_on && (state_q != RRS_ST_RUN) |=> state_q == RRS_ST_STOP)
        else $error("run contact on but not stopped");

    a_pause_two_ends: assert property ( // R8
        $rose(hold_q) |-> $past(pstat_q, 2))
        else $error("paused without flag a scan earlier");

    a_pause_holds: assert property ( // R9
        (state_q == RRS_ST_PAUSE) |-> hold_q && !off_q && !exec_q)
        else $error("pause did not hold outputs");

    a_reset_refused: assert property ( // R14
        cmd_valid && (cmd_code == `RRS_CMD_RESET) && !diag_error &&
        (state_q != RRS_ST_STOP) |=> nak_q && !cpu_reset)
        else $error("reset accepted while running");

    a_reset_enable: assert property ( // R16
        cpu_reset |-> $past(reset_enable))
        else $error("reset without enable parameter");

    a_lclr_stopped: assert property ( // R18
        clear_unlatched |-> $past(state_q) == RRS_ST_STOP)
        else $error("latch clear while not stopped");

    a_stop_priority: assert property ( // R20
        key_s_q && eval && stop_any |=> state_q == RRS_ST_STOP && !pstat_q)
        else $error("stop lost priority");

    a_shared_contact: assert property ( // R11
        run_contact_en && pause_contact_en &&
        (pause_contact_sel == run_contact_sel) |-> !pause_contact_on)
        else $error("shared pause contact acted");

    c_remote_stop_run: cover property (
        (state_q == RRS_ST_STOP) ##[1:20] restart_q);
    c_pause_entry: cover property (
        pstat_q ##[1:50] (state_q == RRS_ST_PAUSE));
    c_step_mode: cover property (
        (state_q == RRS_ST_STEP) ##[1:10] step_exec_q);
    c_remote_reset: cover property (cpu_reset);

endmodule // rrs_run_ctrl

/* inc/rrs_consts.svh */
`ifndef RRS_CONSTS_SVH
`define RRS_CONSTS_SVH

// input image size, X0 through 1FFF
`define RRS_NUM_X        8192
`define RRS_SEL_W        13
`define RRS_STEP_W       16

// command codes
`define RRS_CMD_W        3
`define RRS_CMD_RUN      3'h0
`define RRS_CMD_STOP     3'h1
`define RRS_CMD_PAUSE    3'h2
`define RRS_CMD_STEP     3'h3
`define RRS_CMD_RESET    3'h4
`define RRS_CMD_LCLR     3'h5

// command sources
`define RRS_SRC_TOOL     1'h0
`define RRS_SRC_SERIAL   1'h1
`define RRS_NUM_SRC      2

`endif

/* inc/rrs_pkg.sv */
package rrs_pkg;
    typedef enum logic [1:0] {
        RRS_ST_STOP  = 2'h0,
        RRS_ST_RUN   = 2'h1,
        RRS_ST_PAUSE = 2'h2,
        RRS_ST_STEP  = 2'h3
    } rrs_state_t;
endpackage

/* tb/rrs_cmd_host.sv */
`timescale 1ns/10ps
`include "rrs_consts.svh"

// stands in for the programming tool and the serial module
module rrs_cmd_host (
    input  wire logic                  clk,
    input  wire logic                  cmd_ack,
    input  wire logic                  cmd_nak,
    output logic                       cmd_valid,
    output logic [`RRS_CMD_W-1:0]      cmd_code,
    output logic                       cmd_src,
    output logic [`RRS_STEP_W-1:0]     cmd_step_addr,
    output logic                       reset_enable
);
    initial begin
        cmd_valid     = 1'b0;
        cmd_code      = 3'h7;
        cmd_src       = 1'b0;
        cmd_step_addr = 16'h0000;
        reset_enable  = 1'b0;
    end

    // enable written ahead of any reset command
    task automatic allow_reset(input logic en);
        @(posedge clk);
        reset_enable <= en;
    endtask

    // one pulse per command; code and address scrambled once taken
    task automatic send(input logic [2:0] code, input logic src, input logic [15:0] addr,
                        output logic ack, output logic nak);
        @(posedge clk);
        cmd_valid     <= 1'b1;
        cmd_code      <= code;
        cmd_src       <= src;
        cmd_step_addr <= addr;
        @(posedge clk);
        cmd_valid     <= 1'b0;
        cmd_code      <= ~code;
        cmd_step_addr <= ~addr;
        // answer stands only the cycle after the taking edge
        #1;
        ack = cmd_ack;
        nak = cmd_nak;
    endtask
endmodule // rrs_cmd_host

/* tb/rrs_run_ctrl_tb.sv */
`timescale 1ns/10ps
`include "rrs_consts.svh"

module rrs_run_ctrl_tb;
    import rrs_pkg::*;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          key_run = 1'b1;
    logic [8191:0] x_in = '0;
    logic          run_contact_en = 1'b0;
    logic          pause_contact_en = 1'b0;
    logic          pause_enable_flag = 1'b0;
    logic [12:0]   run_contact_sel = 13'h1FFF;
    logic [12:0]   pause_contact_sel = 13'h0005;
    logic          diag_error = 1'b0;
    logic          scan_end = 1'b0;
    logic          cmd_valid, cmd_src, reset_enable, ack, nak, rst_seen;
    logic [2:0]    cmd_code;
    logic [15:0]   cmd_step_addr, step_addr;
    rrs_state_t    run_state;
    logic          exec_enable, restart_step0, outputs_off, outputs_hold, pause_status_flag;
    logic          step_exec, cpu_reset, clear_unlatched, clear_latch_clearable;
    logic          cmd_ack, cmd_nak;
    int            num_errors = 0;
    int            cmp_count = 0;

    always #5 clk = ~clk;

    rrs_run_ctrl u_rrs_run_ctrl (.clk, .rst_n, .key_run, .x_in, .run_contact_en,
        .run_contact_sel, .pause_contact_en, .pause_contact_sel, .pause_enable_flag,
        .reset_enable, .diag_error, .scan_end, .cmd_valid, .cmd_code, .cmd_src,
        .cmd_step_addr, .run_state, .exec_enable, .restart_step0, .outputs_off,
        .outputs_hold, .pause_status_flag, .step_exec, .step_addr, .cpu_reset,
        .clear_unlatched, .clear_latch_clearable, .cmd_ack, .cmd_nak);

    rrs_cmd_host u_rrs_cmd_host (.clk, .cmd_ack, .cmd_nak, .cmd_valid, .cmd_code,
        .cmd_src, .cmd_step_addr, .reset_enable);

    task automatic check_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // bounded wait; remembers a restart pulse seen on the way
    task automatic wait_state(input rrs_state_t exp);
        int n;
        n = 0;
        rst_seen = 1'b0;
        while (run_state !== exp && n < 20) begin
            @(posedge clk);
            #1;
            rst_seen = rst_seen | restart_step0;
            n++;
        end
        check_val(16'(run_state), 16'(exp));
    endtask

    task automatic cmd(input logic [2:0] code, input logic src);
        u_rrs_cmd_host.send(code, src, 16'h0123, ack, nak);
    endtask

    // three idle cycles let the registered outputs settle
    task automatic scan;
        @(posedge clk);
        scan_end <= 1'b1;
        @(posedge clk);
        scan_end <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic t_reset_and_run;
        repeat (4) @(posedge clk);
        #1;
        check_val(16'(run_state), 16'(RRS_ST_STOP));
        check_bit(outputs_off, 1'b1);
        @(posedge clk);
        rst_n <= 1'b1;
        wait_state(RRS_ST_RUN);
        check_bit(exec_enable, 1'b1);
    endtask

    task automatic t_remote_stop;
        cmd(`RRS_CMD_STOP, `RRS_SRC_TOOL);
        check_bit(ack, 1'b1);
        cmd(`RRS_CMD_STOP, `RRS_SRC_SERIAL);
        repeat (5) @(posedge clk);
        #1;
        check_val(16'(run_state), 16'(RRS_ST_RUN));
        scan();
        wait_state(RRS_ST_STOP);
        check_bit(outputs_off, 1'b1);
        check_bit(exec_enable, 1'b0);
        cmd(`RRS_CMD_RUN, `RRS_SRC_TOOL);
        repeat (5) @(posedge clk);
        #1;
        check_val(16'(run_state), 16'(RRS_ST_STOP));
        cmd(`RRS_CMD_RUN, `RRS_SRC_SERIAL);
        wait_state(RRS_ST_RUN);
        check_bit(rst_seen, 1'b1);
    endtask

    task automatic t_refuse_running;
        u_rrs_cmd_host.allow_reset(1'b1);
        cmd(`RRS_CMD_RESET, `RRS_SRC_TOOL);
        check_bit(nak, 1'b1);
        check_bit(cpu_reset, 1'b0);
        cmd(`RRS_CMD_LCLR, `RRS_SRC_SERIAL);
        check_bit(nak, 1'b1);
        check_bit(clear_unlatched, 1'b0);
        cmd(`RRS_CMD_STEP, `RRS_SRC_SERIAL);
        check_bit(nak, 1'b1);
        cmd(3'h7, `RRS_SRC_TOOL);
        check_bit(nak, 1'b1);
        @(posedge clk);
        diag_error <= 1'b1;
        cmd(`RRS_CMD_RESET, `RRS_SRC_SERIAL);
        check_bit(cpu_reset, 1'b1);
        @(posedge clk);
        diag_error <= 1'b0;
        wait_state(RRS_ST_RUN);
    endtask

    task automatic t_pause_cmd;
        cmd(`RRS_CMD_PAUSE, `RRS_SRC_SERIAL);
        scan();
        check_bit(pause_status_flag, 1'b1);
        check_val(16'(run_state), 16'(RRS_ST_RUN));
        scan();
        wait_state(RRS_ST_PAUSE);
        check_bit(outputs_hold, 1'b1);
        check_bit(outputs_off, 1'b0);
        cmd(`RRS_CMD_RUN, `RRS_SRC_SERIAL);
        wait_state(RRS_ST_RUN);
        check_bit(rst_seen, 1'b1);
    endtask

    // contacts pass a two-flop synchroniser, hence the lead-in cycles
    task automatic t_contacts;
        @(posedge clk);
        pause_contact_en <= 1'b1;
        pause_enable_flag <= 1'b1;
        x_in[5] <= 1'b1;
        repeat (3) @(posedge clk);
        scan();
        check_bit(pause_status_flag, 1'b1);
        scan();
        wait_state(RRS_ST_PAUSE);
        @(posedge clk);
        pause_enable_flag <= 1'b0;
        wait_state(RRS_ST_RUN);
        check_bit(rst_seen, 1'b1);
        @(posedge clk);
        x_in[5] <= 1'b0;
        run_contact_en <= 1'b1;
        x_in[8191] <= 1'b1;
        repeat (3) @(posedge clk);
        scan();
        wait_state(RRS_ST_STOP);
        @(posedge clk);
        x_in[8191] <= 1'b0;
        wait_state(RRS_ST_RUN);
        // shared contact: pause stays dead, run contact still stops
        @(posedge clk);
        pause_contact_sel <= 13'h1FFF;
        pause_enable_flag <= 1'b1;
        x_in[8191] <= 1'b1;
        repeat (3) @(posedge clk);
        scan();
        wait_state(RRS_ST_STOP);
        check_bit(pause_status_flag, 1'b0);
        @(posedge clk);
        x_in[8191] <= 1'b0;
        pause_contact_sel <= 13'h0005;
        pause_enable_flag <= 1'b0;
        run_contact_en <= 1'b0;
        wait_state(RRS_ST_RUN);
    endtask

    task automatic t_priority_and_stopped;
        cmd(`RRS_CMD_PAUSE, `RRS_SRC_TOOL);
        cmd(`RRS_CMD_STEP, `RRS_SRC_TOOL);
        cmd(`RRS_CMD_STOP, `RRS_SRC_SERIAL);
        scan();
        wait_state(RRS_ST_STOP);
        u_rrs_cmd_host.allow_reset(1'b0);
        cmd(`RRS_CMD_RESET, `RRS_SRC_TOOL);
        check_bit(nak, 1'b1);
        cmd(`RRS_CMD_LCLR, `RRS_SRC_SERIAL);
        check_bit(clear_unlatched, 1'b1);
        check_bit(clear_latch_clearable, 1'b1);
        u_rrs_cmd_host.allow_reset(1'b1);
        cmd(`RRS_CMD_RESET, `RRS_SRC_SERIAL);
        check_bit(cpu_reset, 1'b1);
        wait_state(RRS_ST_RUN);
    endtask

    task automatic t_step_and_key;
        cmd(`RRS_CMD_STEP, `RRS_SRC_TOOL);
        check_bit(ack, 1'b1);
        scan();
        wait_state(RRS_ST_STEP);
        check_val(step_addr, 16'h0123);
        @(posedge clk);
        key_run <= 1'b0;
        wait_state(RRS_ST_STOP);
        check_bit(outputs_off, 1'b1);
        cmd(`RRS_CMD_RUN, `RRS_SRC_TOOL);
        repeat (5) @(posedge clk);
        #1;
        check_val(16'(run_state), 16'(RRS_ST_STOP));
    endtask

    // whole run is under two hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        t_reset_and_run();
        t_remote_stop();
        t_refuse_running();
        t_pause_cmd();
        t_contacts();
        t_priority_and_stopped();
        t_step_and_key();
        report_and_stop();
    end
endmodule // rrs_run_ctrl_tb
